// ===== tb_top.sv
`timescale 1ns/100ps
module tb_top
   import tch_pkg::*;
;
   logic        clock = 1'b0;
   logic        rstn = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic        hready;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic [7:0]  mode = 8'hff;
   logic [7:0]  mask = 8'h00;
   logic [7:0]  odata = 8'h00;
   logic [7:0]  match = 8'h00;
   logic [7:0]  force_c = 8'h00;
   logic        wrap = 1'b0;
   logic [7:0]  ext_level = 8'h00;
   logic [7:0]  ext_oe = 8'h00;
   logic [7:0]  pin_in, pin_out, pin_oe, capture_event;
   logic        timer_irq;
   logic        pin;
   logic [31:0] rdata;
   int          errors = 0;
   int          n_compared = 0;

   assign hready = hreadyout;
   // Half period of 20 ns gives the 25 MHz clock
   always #20 clock = ~clock;

   tch_action_edge_ctrl i_dut (.clock(clock), .rstn(rstn), .hsel(1'b1),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .channel_mode_select_reg(mode),
      .ch7_override_mask(mask), .ch7_override_data(odata),
      .compare_match(match), .force_compare(force_c),
      .counter_wrap_event(wrap), .channel_pin_in(pin_in),
      .channel_pin_out(pin_out), .channel_pin_oe(pin_oe),
      .capture_event(capture_event), .timer_irq(timer_irq));

   tch_pin_model i_pins (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe),
      .ext_level(ext_level), .ext_oe(ext_oe), .pin_level(pin_in));

   ////////////////////////////////////////////////////////////////////////
   task wrap_up;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
      n_compared++;
      if (seen !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, e, seen);
      end
   endtask

   // Bounded wait on hready; a hang ends the run as a mismatch
   task wait_ready;
      int k;
      k = 0;
      do begin
         @(posedge clock);
         k++;
      end while (hready !== 1'b1 && k < 20);
      if (hready !== 1'b1) begin
         errors++;
         wrap_up();
      end
   endtask

   // One single AHB word transfer: address phase, then data phase.
   // Read data is taken at the closing edge; the task then waits for the
   // falling edge so that a write has landed before anyone looks at it.
   task bus(input logic w, input logic [31:0] a, input logic [7:0] d);
      @(posedge clock);
      haddr <= a;
      hwrite <= w;
      htrans <= HTRANS_NONSEQ;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      wait_ready();
      rdata = hrdata;
      @(negedge clock);
   endtask

   task rd(input string nm, input logic [31:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(nm, rdata, {24'h0, e});
   endtask

   // One-cycle event pulses, sampled once settled after the update edge
   task pulse(input logic [7:0] m, input logic [7:0] f, input logic w);
      @(posedge clock);
      match <= m;
      force_c <= f;
      wrap <= w;
      @(posedge clock);
      match <= 8'h00;
      force_c <= 8'h00;
      wrap <= 1'b0;
      @(negedge clock);
   endtask

   task edge_chk(input logic lvl, input logic e);
      @(posedge clock);
      ext_level <= {7'h0, lvl};
      @(negedge clock);
      chk("capture", {31'h0, capture_event[0]}, {31'h0, e});
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge clock);
      rstn <= 1'b1;
      // Reset values and read-write access, then unmapped places
      for (int i = 0; i < 6; i++) begin
         rd("reset", 32'h1c + 32'(i * 4), RST_ACTION);
         bus(1'b1, 32'h1c + 32'(i * 4), 8'h5a + 8'(i));
         rd("rw", 32'h1c + 32'(i * 4), 8'h5a + 8'(i));
      end
      bus(1'b1, 32'h3c, 8'hff);
      rd("unmapped", 32'h3c, 8'h00);
      bus(1'b1, 32'h00, 8'hff);
      rd("unmapped0", 32'h00, 8'h00);
      // Second reset mid-run brings every register back to zero
      rstn <= 1'b0;
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      rd("reset2", 32'h20, RST_ACTION);
      $display("test registers done");
      // Every action code on channel 3, all channels in compare mode
      pin = 1'b0;
      for (int c = 3; c >= 0; c--) begin
         bus(1'b1, 32'h24, {2'(c), 6'h00});
         chk("oe3", {31'h0, pin_oe[3]}, {31'h0, c != 0});
         pulse(8'h08, 8'h00, 1'b0);
         pin = (c == 3) ? 1'b1 : (c == 2) ? 1'b0 : (c == 1) ? ~pin : pin;
         chk("pin3", {31'h0, pin_out[3]}, {31'h0, pin});
      end
      $display("test actions done");
      // Flag from the compare, gated by its own enable bit only
      rd("flag", 32'h38, 8'h08);
      bus(1'b1, 32'h30, 8'hf7);
      chk("irq", {31'h0, timer_irq}, 32'h0);
      bus(1'b1, 32'h30, 8'h08);
      chk("irq", {31'h0, timer_irq}, 32'h1);
      bus(1'b1, 32'h38, 8'h08);
      chk("irq", {31'h0, timer_irq}, 32'h0);
      $display("test interrupt done");
      // Overflow toggle on channel 2
      bus(1'b1, 32'h1c, 8'h04);
      pulse(8'h00, 8'h00, 1'b1);
      chk("tov", {31'h0, pin_out[2]}, 32'h1);
      mode <= 8'hfb;
      pulse(8'h00, 8'h00, 1'b1);
      chk("tov_cap", {31'h0, pin_out[2]}, 32'h1);
      mode <= 8'hff;
      bus(1'b1, 32'h24, 8'h30);
      pulse(8'h00, 8'h04, 1'b1);
      chk("tov_force", {31'h0, pin_out[2]}, 32'h0);
      mask <= 8'h04;
      pulse(8'h80, 8'h00, 1'b1);
      chk("tov_ovr", {31'h0, pin_out[2]}, 32'h0);
      $display("test overflow done");
      // Channel 7 override against channel 1 own action
      bus(1'b1, 32'h1c, 8'h00);
      mask <= 8'h02;
      odata <= 8'h02;
      bus(1'b1, 32'h24, 8'h08);
      bus(1'b1, 32'h20, 8'hc0);
      pulse(8'h82, 8'h00, 1'b0);
      chk("ovr_eq", {31'h0, pin_out[1]}, 32'h1);
      chk("pin7", {31'h0, pin_out[7]}, 32'h1);
      chk("oe1", {31'h0, pin_oe[1]}, 32'h1);
      pulse(8'h02, 8'h00, 1'b0);
      chk("own1", {31'h0, pin_out[1]}, 32'h0);
      pulse(8'h80, 8'h00, 1'b0);
      chk("ovr1", {31'h0, pin_out[1]}, 32'h1);
      pulse(8'h02, 8'h00, 1'b0);
      mask <= 8'h80;
      odata <= 8'h02;
      pulse(8'h80, 8'h00, 1'b0);
      chk("unmasked", {31'h0, pin_out[1]}, 32'h0);
      chk("ovr7", {31'h0, pin_out[7]}, 32'h0);
      // Channel 7 in capture mode gives no override event at all
      mask <= 8'h02;
      mode <= 8'h7f;
      pulse(8'h80, 8'h00, 1'b0);
      chk("ovr_nomode", {31'h0, pin_out[1]}, 32'h0);
      mode <= 8'hff;
      mask <= 8'h00;
      bus(1'b1, 32'h20, 8'h00);
      $display("test override done");
      // Capture edge codes on channel 0, driven from outside
      mode <= 8'hfe;
      ext_oe <= 8'h01;
      for (int c = 0; c < 4; c++) begin
         bus(1'b1, 32'h2c, 8'(c));
         edge_chk(1'b1, c[0]);
         edge_chk(1'b0, c[1]);
      end
      mode <= 8'hff;
      edge_chk(1'b1, 1'b0);
      $display("test capture done");
      wrap_up();
   end
endmodule

// ===== tch_action_edge_ctrl.sv
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/100ps
module tch_action_edge_ctrl
   import tch_pkg::*;
#(
   parameter int NUM_CH = CHANNELS
) (
   input  wire logic                clock,
   input  wire logic                rstn,
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic [31:0]              hrdata,
   output logic                     hreadyout,
   output logic                     hresp,
   input  wire logic [NUM_CH-1:0]   channel_mode_select_reg,
   input  wire logic [NUM_CH-1:0]   ch7_override_mask,
   input  wire logic [NUM_CH-1:0]   ch7_override_data,
   input  wire logic [NUM_CH-1:0]   compare_match,
   input  wire logic [NUM_CH-1:0]   force_compare,
   input  wire logic                counter_wrap_event,
   input  wire logic [NUM_CH-1:0]   channel_pin_in,
   output logic [NUM_CH-1:0]        channel_pin_out,
   output logic [NUM_CH-1:0]        channel_pin_oe,
   output logic [NUM_CH-1:0]        capture_event,
   output logic                     timer_irq
);

////////////////////////////////////////////////////////////////////////////
   // The byte-wide layout fixes the channel count
   if (NUM_CH != CHANNELS) begin : g_bad_width
      $error("tch_action_edge_ctrl supports exactly eight channels");
   end

   logic [7:0] overflow_toggle_enable;
   logic [7:0] compare_action_hi;
   logic [7:0] compare_action_lo;
   logic [7:0] capture_edge_hi;
   logic [7:0] capture_edge_lo;
   logic [7:0] channel_irq_enable;
   logic [7:0] channel_flag_reg;
   logic       wr_pend;
   logic [5:0] wr_index;

////////////////////////////////////////////////////////////////////////////
   // Address phase decode; hsize is not decoded, every transfer is taken as a word
   wire        addr_ok  = hsel & hready & (htrans == HTRANS_NONSEQ);
   wire  [5:0] rd_index = haddr[IDX_MSB:IDX_LSB];
   wire  [7:0] wr_byte  = hwdata[7:0];

   // Data phase write strobes, one per register
   wire wr_ovf   = wr_pend & (wr_index == IDX_OVF_TOGGLE);
   wire wr_act_h = wr_pend & (wr_index == IDX_ACTION_HI);
   wire wr_act_l = wr_pend & (wr_index == IDX_ACTION_LO);
   wire wr_edg_h = wr_pend & (wr_index == IDX_EDGE_HI);
   wire wr_edg_l = wr_pend & (wr_index == IDX_EDGE_LO);
   wire wr_ie    = wr_pend & (wr_index == IDX_IRQ_ENABLE);
   wire wr_flag  = wr_pend & (wr_index == IDX_CHANNEL_FLAG);

   // Channel events that raise flags; forced compares raise none
   wire [7:0] compare_ok = compare_match & channel_mode_select_reg;
   wire [7:0] chan_event = compare_ok | capture_event;

   // Next register values, including a write still in its data phase
   wire [7:0] next_ovf   = wr_ovf   ? wr_byte : overflow_toggle_enable;
   wire [7:0] next_act_h = wr_act_h ? wr_byte : compare_action_hi;
   wire [7:0] next_act_l = wr_act_l ? wr_byte : compare_action_lo;
   wire [7:0] next_edg_h = wr_edg_h ? wr_byte : capture_edge_hi;
   wire [7:0] next_edg_l = wr_edg_l ? wr_byte : capture_edge_lo;
   wire [7:0] next_ie    = wr_ie    ? wr_byte : channel_irq_enable;
   // Writing one clears a flag, but a new event in that cycle keeps it set
   wire [7:0] flag_clear = wr_flag ? wr_byte : 8'h00;
   wire [7:0] next_flag  = (channel_flag_reg & ~flag_clear)
                           | chan_event;

   // Read mux over next values so a read right after a write sees it
   logic [7:0] rd_byte;
   always_comb begin
      case (rd_index)
         IDX_OVF_TOGGLE:   rd_byte = next_ovf;
         IDX_ACTION_HI:    rd_byte = next_act_h;
         IDX_ACTION_LO:    rd_byte = next_act_l;
         IDX_EDGE_HI:      rd_byte = next_edg_h;
         IDX_EDGE_LO:      rd_byte = next_edg_l;
         IDX_IRQ_ENABLE:   rd_byte = next_ie;
         IDX_CHANNEL_FLAG: rd_byte = next_flag;
         default:          rd_byte = 8'h00;
      endcase
   end

////////////////////////////////////////////////////////////////////////////
   // Bus tracking: zero wait states, so every data phase completes at once
   always_ff @(posedge clock) begin
      if (!rstn) begin
         wr_pend  <= 1'b0;
         wr_index <= 6'h00;
         hrdata   <= 32'h0000_0000;
      end else begin
         wr_pend  <= addr_ok & hwrite;
         wr_index <= rd_index;
         if (addr_ok && !hwrite) begin
            hrdata <= {24'h00_0000, rd_byte};
         end
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = HRESP_OKAY;

   // Control registers, writable at any time
   always_ff @(posedge clock) begin
      if (!rstn) begin
         overflow_toggle_enable <= RST_OVF_TOGGLE;
         compare_action_hi      <= RST_ACTION;
         compare_action_lo      <= RST_ACTION;
         capture_edge_hi        <= RST_EDGE;
         capture_edge_lo        <= RST_EDGE;
         channel_irq_enable     <= RST_IRQ_ENABLE;
         channel_flag_reg       <= RST_CHANNEL_FLAG;
      end else begin
         overflow_toggle_enable <= next_ovf;
         compare_action_hi      <= next_act_h;
         compare_action_lo      <= next_act_l;
         capture_edge_hi        <= next_edg_h;
         capture_edge_lo        <= next_edg_l;
         channel_irq_enable     <= next_ie;
         channel_flag_reg       <= next_flag;
      end
   end

   // Level request, no edge memory beyond the flags themselves
   assign timer_irq = |(channel_flag_reg & channel_irq_enable);

////////////////////////////////////////////////////////////////////////////
   // Bit pairs, channels 7..0 from hi byte down to lo byte
   wire [15:0] action_all = {compare_action_hi, compare_action_lo};
   wire [15:0] edge_all   = {capture_edge_hi, capture_edge_lo};
   // Override only counts when channel 7 itself is comparing
   wire        ch7_event  = compare_ok[7];

   for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
      tch_channel #(
         .IS_CH7 (ch == NUM_CH - 1)
      ) u_chan (
         .clock               (clock),
         .rstn                (rstn),
         .compare_mode        (channel_mode_select_reg[ch]),
         .overflow_toggle_bit (overflow_toggle_enable[ch]),
         .action              (action_all[2*ch +: 2]),
         .edge_sel            (edge_all[2*ch +: 2]),
         .ch7_override_mask   (ch7_override_mask[ch]),
         .ch7_override_data   (ch7_override_data[ch]),
         .ch7_event           (ch7_event),
         .own_match           (compare_match[ch]),
         .force_compare       (force_compare[ch]),
         .counter_wrap_event  (counter_wrap_event),
         .pin_in              (channel_pin_in[ch]),
         .pin_out             (channel_pin_out[ch]),
         .pin_oe              (channel_pin_oe[ch]),
         .capture_event       (capture_event[ch])
      );
   end

////////////////////////////////////////////////////////////////////////////
   sequence s_ovf_write_addr;
      addr_ok && hwrite && rd_index == IDX_OVF_TOGGLE;
   endsequence
   sequence s_ovf_write_data;
      ##1 1'b1;
   endsequence

   a_ovf_reg_write: assert property (@(posedge clock) disable iff (!rstn)
      s_ovf_write_addr ##0 s_ovf_write_data
      |=> overflow_toggle_enable == $past(hwdata[7:0]))
      else $error("toggle register write lost");
   a_flag_event_set: assert property (@(posedge clock) disable iff (!rstn)
      chan_event != 8'h00
      |=> (channel_flag_reg & $past(chan_event)) == $past(chan_event))
      else $error("channel flag not set by event");
   a_irq_after_event: assert property (@(posedge clock) disable iff (!rstn)
      (chan_event & channel_irq_enable) != 8'h00 && !wr_ie
      |=> timer_irq)
      else $error("enabled event gave no interrupt");
   a_irq_masked: assert property (@(posedge clock) disable iff (!rstn)
      channel_irq_enable == 8'h00 |-> !timer_irq)
      else $error("interrupt while all enables clear");
   a_unmapped_read: assert property (@(posedge clock) disable iff (!rstn)
      addr_ok && !hwrite && rd_index == 6'h00 |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
endmodule

// ===== tch_channel.sv
`timescale 1ns/100ps
module tch_channel
   import tch_pkg::*;
#(
   parameter bit IS_CH7 = 1'b0
) (
   input  wire logic       clock,
   input  wire logic       rstn,
   input  wire logic       compare_mode,
   input  wire logic       overflow_toggle_bit,
   input  wire logic [1:0] action,
   input  wire logic [1:0] edge_sel,
   input  wire logic       ch7_override_mask,
   input  wire logic       ch7_override_data,
   input  wire logic       ch7_event,
   input  wire logic       own_match,
   input  wire logic       force_compare,
   input  wire logic       counter_wrap_event,
   input  wire logic       pin_in,
   output logic            pin_out,
   output logic            pin_oe,
   output logic            capture_event
);

////////////////////////////////////////////////////////////////////////////
   logic pin_prev;
   logic next_pin;
   wire  override_hit = ch7_event & ch7_override_mask & compare_mode;
   wire  toggle_hit   = counter_wrap_event & overflow_toggle_bit
                        & compare_mode;
   // Channel 7 own action is silenced while its mask bit routes data
   wire  own_allowed  = compare_mode & ~(IS_CH7 & ch7_override_mask);
   wire  own_hit      = own_allowed & (own_match | force_compare);
   wire  rise         = pin_in & ~pin_prev;
   wire  fall         = ~pin_in & pin_prev;

   // Priority: channel 7 override, then overflow toggle, then own action
   always_comb begin
      next_pin = pin_out;
      if (override_hit) begin
         next_pin = ch7_override_data;
      end else if (toggle_hit) begin
         next_pin = ~pin_out;
      end else if (own_hit) begin
         case (action)
            ACT_TOGGLE:     next_pin = ~pin_out;
            ACT_DRIVE_LOW:  next_pin = 1'b0;
            ACT_DRIVE_HIGH: next_pin = 1'b1;
            default:        next_pin = pin_out;
         endcase
      end
   end

   // Pin state and capture history
   always_ff @(posedge clock) begin
      if (!rstn) begin
         pin_out  <= RST_PIN;
         pin_prev <= 1'b0;
      end else begin
         pin_out  <= next_pin;
         pin_prev <= pin_in;
      end
   end

   // Pin is taken over by the compare logic once any action bit is set
   assign pin_oe = (action != ACT_DISCONNECT)
                   | (ch7_override_mask & compare_mode);

   // Edge detector only listens while the channel is in capture mode
   assign capture_event = ~compare_mode
                          & ((rise & edge_sel[0]) | (fall & edge_sel[1]));

////////////////////////////////////////////////////////////////////////////
   a_override_data: assert property (@(posedge clock) disable iff (!rstn)
      override_hit |=> pin_out == $past(ch7_override_data))
      else $error("override data not on pin");
   a_toggle_overflow: assert property (@(posedge clock) disable iff (!rstn)
      toggle_hit && !override_hit |=> pin_out != $past(pin_out))
      else $error("overflow toggle missing");
   a_capture_quiet: assert property (@(posedge clock) disable iff (!rstn)
      !compare_mode |=> $stable(pin_out))
      else $error("pin moved in capture mode");
   a_drive_high: assert property (@(posedge clock) disable iff (!rstn)
      own_hit && !override_hit && !toggle_hit
      && action == ACT_DRIVE_HIGH |=> pin_out)
      else $error("drive high action failed");
   a_rise_capture: assert property (@(posedge clock) disable iff (!rstn)
      $rose(pin_in) && !compare_mode && edge_sel[0]
      |-> capture_event)
      else $error("rising edge not captured");
endmodule

// ===== tch_pin_model.sv
`timescale 1ns/100ps
// Far side of the channel pins: outside drivers plus the wire itself
module tch_pin_model
   import tch_pkg::*;
(
   input  wire logic       clock,
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   input  wire logic [7:0] ext_level,
   input  wire logic [7:0] ext_oe,
   output logic [7:0]      pin_level
);
   logic [7:0] float_level = 8'h55;

   ////////////////////////////////////////////////////////////////////////
   // A wire nobody drives wanders, so a stale level can never look valid
   always_ff @(posedge clock) begin
      float_level <= ~float_level;
   end

   // Timer drive wins; the outside only drives pins the timer released
   assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_level)
                    | (~pin_oe & ~ext_oe & float_level);
endmodule

// ===== tch_pkg.sv
package tch_pkg;
   // Channel count served by the register layout
   localparam int CHANNELS = 8;
   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_OVF_TOGGLE   = 6'h07;
   localparam logic [5:0] IDX_ACTION_HI    = 6'h08;
   localparam logic [5:0] IDX_ACTION_LO    = 6'h09;
   localparam logic [5:0] IDX_EDGE_HI      = 6'h0a;
   localparam logic [5:0] IDX_EDGE_LO      = 6'h0b;
   localparam logic [5:0] IDX_IRQ_ENABLE   = 6'h0c;
   localparam logic [5:0] IDX_CHANNEL_FLAG = 6'h0e;
   // Index field inside the byte address
   localparam int IDX_LSB = 2;
   localparam int IDX_MSB = 7;
   // Reset values
   localparam logic [7:0] RST_OVF_TOGGLE   = 8'h00;
   localparam logic [7:0] RST_ACTION       = 8'h00;
   localparam logic [7:0] RST_EDGE         = 8'h00;
   localparam logic [7:0] RST_IRQ_ENABLE   = 8'h00;
   localparam logic [7:0] RST_CHANNEL_FLAG = 8'h00;
   localparam logic       RST_PIN          = 1'b0;
   // Compare action codes {action_high_bit, action_low_bit}
   localparam logic [1:0] ACT_DISCONNECT = 2'h0;
   localparam logic [1:0] ACT_TOGGLE     = 2'h1;
   localparam logic [1:0] ACT_DRIVE_LOW  = 2'h2;
   localparam logic [1:0] ACT_DRIVE_HIGH = 2'h3;
   // Edge select codes {edge_select_high, edge_select_low}
   localparam logic [1:0] EDGE_OFF     = 2'h0;
   localparam logic [1:0] EDGE_RISING  = 2'h1;
   localparam logic [1:0] EDGE_FALLING = 2'h2;
   localparam logic [1:0] EDGE_ANY     = 2'h3;
   // AHB encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic       HRESP_OKAY    = 1'b0;
endpackage
